// file: design/sspi_core.sv
// clock-stop spi serial port, master and slave
`timescale 1ns/1ps
`default_nettype none
module sspi_core
    import sspi_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // configuration
    input wire logic [1:0] clock_stop_mode_select,
    input wire logic tx_clock_polarity,
    input wire logic generator_source_select,
    input wire logic [SSPI_DIV_W-1:0] generator_divide_value,
    input wire logic tx_clock_direction,
    input wire logic rx_clock_direction,
    input wire logic tx_sync_direction,
    input wire logic rx_sync_direction,
    input wire logic tx_sync_polarity,
    input wire logic rx_sync_polarity,
    // user side
    input wire logic tx_start,
    input wire logic [SSPI_WORD_W-1:0] tx_word,
    output logic busy,
    output logic [SSPI_WORD_W-1:0] rx_word,
    output logic rx_valid,
    // pins
    input wire logic generator_ext_clock_i,
    input wire logic serial_bit_clock_i,
    output logic serial_bit_clock_o,
    output logic serial_bit_clock_oe,
    input wire logic tx_frame_sync_enable_i,
    output logic tx_frame_sync_enable_o,
    output logic tx_frame_sync_enable_oe,
    input wire logic rx_frame_sync_enable_i,
    output logic tx_serial_data_o,
    output logic tx_serial_data_oe,
    input wire logic rx_serial_data_i
);

    // =====================================================
    // configuration decode
    sspi_state_t st_ff;
    sspi_state_t nxt_st;
    logic mode_ok;
    logic master;
    logic slave;
    logic [SSPI_DIV_W:0] div_p1;
    logic [SSPI_DIV_W-1:0] hi_len;
    logic [SSPI_DIV_W-1:0] lo_len;
    logic [SSPI_DIV_W-1:0] cur_len;
    logic phase_end;

    assign mode_ok = (clock_stop_mode_select == SSPI_CSTOP_HALF) && !tx_clock_polarity;
    assign master = mode_ok && tx_clock_direction && tx_sync_direction
                    && !rx_clock_direction && !rx_sync_direction;
    assign slave = mode_ok && !tx_clock_direction && !tx_sync_direction
                   && !rx_clock_direction && !rx_sync_direction;
    assign div_p1 = {1'b0, generator_divide_value} + {{SSPI_DIV_W{1'b0}}, 1'b1};

    always_comb begin
        if (!generator_divide_value[0] && (generator_divide_value != '0)) begin
            hi_len = (generator_divide_value >> 1) + {{(SSPI_DIV_W-1){1'b0}}, 1'b1};
            lo_len = generator_divide_value >> 1;
        end else begin
            hi_len = div_p1[SSPI_DIV_W:1];
            lo_len = div_p1[SSPI_DIV_W:1];
        end
        if (hi_len == '0) begin
            hi_len = {{(SSPI_DIV_W-1){1'b0}}, 1'b1};
        end
        if (lo_len == '0) begin
            lo_len = {{(SSPI_DIV_W-1){1'b0}}, 1'b1};
        end
    end

    assign cur_len = (st_ff.phase == SSPI_LOW || st_ff.phase == SSPI_TAIL) ? lo_len : hi_len;
    assign phase_end = st_ff.tick && (st_ff.cnt == cur_len - {{(SSPI_DIV_W-1){1'b0}}, 1'b1});

    // =====================================================
    // next state
    always_comb begin
        logic sel_in;
        logic rise;
        logic fall;
        sel_in = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        nxt_st = st_ff;
        nxt_st.rx_valid = 1'b0;
        // pin synchronisers, stable once second and third stage agree
        nxt_st.sy.sclk = {st_ff.sy.sclk[1:0], serial_bit_clock_i};
        nxt_st.sy.tx_frame_sync_enable = {st_ff.sy.tx_frame_sync_enable[1:0], tx_frame_sync_enable_i};
        nxt_st.sy.rx_frame_sync_enable = {st_ff.sy.rx_frame_sync_enable[1:0], rx_frame_sync_enable_i};
        nxt_st.sy.din = {st_ff.sy.din[1:0], rx_serial_data_i};
        nxt_st.sy.ext = {st_ff.sy.ext[1:0], generator_ext_clock_i};
        if (st_ff.sy.sclk[1] == st_ff.sy.sclk[2]) begin
            nxt_st.sclk_st = st_ff.sy.sclk[2];
        end
        if ((st_ff.sy.tx_frame_sync_enable[1] == st_ff.sy.tx_frame_sync_enable[2]) && (st_ff.sy.rx_frame_sync_enable[1] == st_ff.sy.rx_frame_sync_enable[2])) begin
            sel_in = (tx_sync_polarity ? ~st_ff.sy.tx_frame_sync_enable[2] : st_ff.sy.tx_frame_sync_enable[2])
                     | (rx_sync_polarity ? ~st_ff.sy.rx_frame_sync_enable[2] : st_ff.sy.rx_frame_sync_enable[2]);
            nxt_st.sel_st = sel_in;
        end
        if (st_ff.sy.din[1] == st_ff.sy.din[2]) begin
            nxt_st.din_st = st_ff.sy.din[2];
        end
        if (st_ff.sy.ext[1] == st_ff.sy.ext[2]) begin
            nxt_st.ext_st = st_ff.sy.ext[2];
        end
        // generator input tick
        nxt_st.half = ~st_ff.half;
        if (generator_source_select == SSPI_SRC_CPU) begin
            nxt_st.tick = st_ff.half;
        end else begin
            nxt_st.tick = nxt_st.ext_st && !st_ff.ext_st;
        end
        if (st_ff.tick) begin
            nxt_st.cnt = phase_end ? '0 : st_ff.cnt + {{(SSPI_DIV_W-1){1'b0}}, 1'b1};
        end
        rise = nxt_st.sclk_st && !st_ff.sclk_st;
        fall = !nxt_st.sclk_st && st_ff.sclk_st;
        // master capture waits out the synchroniser, so it sees the pin as it stood at the rise
        nxt_st.smp = {st_ff.smp[SSPI_SMP_DLY-2:0], 1'b0};
        if (st_ff.smp[SSPI_SMP_DLY-1]) begin
            nxt_st.rxsh = {st_ff.rxsh[SSPI_WORD_W-2:0], st_ff.din_st};
        end
        // pin directions
        nxt_st.sclk_oe = master;
        nxt_st.fs_oe = master;
        case (st_ff.phase)
            SSPI_IDLE: begin
                nxt_st.sclk = 1'b0;
                nxt_st.doe = 1'b0;
                nxt_st.fs = 1'b0;
                nxt_st.busy = 1'b0;
                nxt_st.bits = '0;
                nxt_st.cnt = '0;
                if (master && tx_start) begin
                    nxt_st.txsh = tx_word;
                    nxt_st.fs = 1'b1;
                    nxt_st.busy = 1'b1;
                    nxt_st.phase = SSPI_LEAD;
                end else if (slave && st_ff.sel_st) begin
                    nxt_st.txsh = tx_word << 1;
                    nxt_st.dout = tx_word[SSPI_WORD_W-1];
                    nxt_st.doe = 1'b1;
                    nxt_st.busy = 1'b1;
                    nxt_st.phase = SSPI_SLV;
                end
            end
            SSPI_LEAD: begin
                if (phase_end) begin
                    nxt_st.dout = st_ff.txsh[SSPI_WORD_W-1];
                    nxt_st.txsh = st_ff.txsh << 1;
                    nxt_st.doe = 1'b1;
                    nxt_st.phase = SSPI_LOW;
                end
            end
            SSPI_LOW: begin
                if (phase_end) begin
                    nxt_st.sclk = 1'b1;
                    nxt_st.smp[0] = 1'b1;
                    nxt_st.bits = st_ff.bits + {{(SSPI_BIT_W-1){1'b0}}, 1'b1};
                    nxt_st.phase = SSPI_HIGH;
                end
            end
            SSPI_HIGH: begin
                if (phase_end) begin
                    nxt_st.sclk = 1'b0;
                    if (st_ff.bits == SSPI_BIT_W'(SSPI_WORD_W)) begin
                        nxt_st.doe = 1'b0;
                        nxt_st.phase = SSPI_TAIL;
                    end else begin
                        nxt_st.dout = st_ff.txsh[SSPI_WORD_W-1];
                        nxt_st.txsh = st_ff.txsh << 1;
                        nxt_st.phase = SSPI_LOW;
                    end
                end
            end
            SSPI_TAIL: begin
                if (phase_end) begin
                    nxt_st.fs = 1'b0;
                    nxt_st.rx_word = nxt_st.rxsh;
                    nxt_st.rx_valid = 1'b1;
                    nxt_st.phase = SSPI_IDLE;
                end
            end
            SSPI_SLV: begin
                if (!st_ff.sel_st || !slave) begin
                    nxt_st.doe = 1'b0;
                    nxt_st.phase = SSPI_IDLE;
                end else if (rise && st_ff.bits != SSPI_BIT_W'(SSPI_WORD_W)) begin
                    nxt_st.rxsh = {st_ff.rxsh[SSPI_WORD_W-2:0], st_ff.din_st};
                    nxt_st.bits = st_ff.bits + {{(SSPI_BIT_W-1){1'b0}}, 1'b1};
                end else if (fall) begin
                    if (st_ff.bits == SSPI_BIT_W'(SSPI_WORD_W)) begin
                        if (st_ff.doe) begin
                            nxt_st.rx_word = st_ff.rxsh;
                            nxt_st.rx_valid = 1'b1;
                        end
                        nxt_st.doe = 1'b0;
                    end else begin
                        nxt_st.dout = st_ff.txsh[SSPI_WORD_W-1];
                        nxt_st.txsh = st_ff.txsh << 1;
                    end
                end
            end
            default: begin
                nxt_st.phase = SSPI_IDLE;
            end
        endcase
        nxt_st.fs_pin = tx_sync_polarity ? ~nxt_st.fs : nxt_st.fs;
    end

    // =====================================================
    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= '0;
            st_ff.sy <= '{sclk: 3'h0, tx_frame_sync_enable: SSPI_SYNC_RST, rx_frame_sync_enable: SSPI_SYNC_RST, din: 3'h0, ext: 3'h0};
            st_ff.phase <= SSPI_IDLE;
            st_ff.fs_pin <= tx_sync_polarity;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =====================================================
    // outputs
    assign busy = st_ff.busy;
    assign rx_word = st_ff.rx_word;
    assign rx_valid = st_ff.rx_valid;
    assign serial_bit_clock_o = st_ff.sclk;
    assign serial_bit_clock_oe = st_ff.sclk_oe;
    assign tx_frame_sync_enable_o = st_ff.fs_pin;
    assign tx_frame_sync_enable_oe = st_ff.fs_oe;
    assign tx_serial_data_o = st_ff.dout;
    assign tx_serial_data_oe = st_ff.doe;

    // =====================================================
    // checks
    chk_tx_fall_edge: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff.phase inside {SSPI_LOW, SSPI_HIGH}) && $past(st_ff.phase) == SSPI_HIGH
        && $changed(st_ff.phase) |-> $fell(st_ff.sclk))
        else $error("tx data moved off a falling clock edge");
    chk_rx_rise_sample: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(st_ff.bits) && st_ff.bits != '0 && st_ff.sclk_oe |-> $rose(st_ff.sclk))
        else $error("receive sample not on rising edge");
    chk_period_sum: assert property (@(posedge clk) disable iff (sys_rst)
        generator_divide_value != '0 |-> ({1'b0, hi_len} + {1'b0, lo_len}) == div_p1)
        else $error("bit clock period wrong");
    chk_high_len: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(st_ff.sclk) ##1 (st_ff.cnt == '0) |-> st_ff.phase == SSPI_HIGH)
        else $error("high phase broken early");
    chk_low_len: assert property (@(posedge clk) disable iff (sys_rst)
        st_ff.phase == SSPI_LOW |-> st_ff.cnt < lo_len)
        else $error("low phase overran");
    chk_cpu_tick: assert property (@(posedge clk) disable iff (sys_rst)
        generator_source_select && $past(generator_source_select) && st_ff.tick |=> !st_ff.tick)
        else $error("cpu generator tick faster than two clocks");
    chk_sync_polarity: assert property (@(posedge clk) disable iff (sys_rst)
        tx_sync_polarity && st_ff.phase == SSPI_LEAD |-> !tx_frame_sync_enable_o)
        else $error("slave enable not active low");
    chk_lead_wait: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(st_ff.fs) |-> !st_ff.sclk [*2])
        else $error("clock rose too soon after enable");
    chk_tail_hold: assert property (@(posedge clk) disable iff (sys_rst)
        st_ff.phase == SSPI_TAIL |-> st_ff.fs && !st_ff.sclk && !st_ff.doe)
        else $error("enable dropped before tail ended");
    chk_data_release: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(st_ff.doe) && st_ff.sclk_oe |-> $fell(st_ff.sclk) || st_ff.phase == SSPI_IDLE)
        else $error("data released off the final falling edge");
    chk_idle_low: assert property (@(posedge clk) disable iff (sys_rst)
        st_ff.phase == SSPI_IDLE |=> !st_ff.sclk)
        else $error("bit clock not idle low");

endmodule
`default_nettype wire

// file: design/sspi_pkg.sv
// constants and carrier types for the clock-stop spi serial port
// What this block does
// - in clock-stop 11b with polarity zero, transmit data changes on bit clock falling edge.
// - receive data is sampled on the bit clock rising edge; sender holds it stable.
// - master bit clock period is generator input period times one plus divide value, or times two when divide is zero.
// - high phase is divide/2+1 periods when even, (divide+1)/2 when odd, one when zero.
// - low phase is divide/2 periods when even, (divide+1)/2 when odd, one when zero.
// - generator input period is two cpu clocks when source select is 1, else external.
// - with tx sync polarity 1, master inverts internal sync for active-low enable; rx sync polarity plays no part.
// - as slave, each frame-sync pin is an active-low enable, inverted before use, only when its own sync polarity is 1.
// - master asserts enable one full bit clock period before first rising edge.
// - master holds enable one low-phase duration after the final falling edge.
// - first bit appears one high phase after enable as master, promptly as slave.
// - transmit data goes high impedance after the last bit, from final falling edge.
package sspi_pkg;

    // =====================================================
    // widths and encodings
    localparam int SSPI_WORD_W = 8;
    localparam int SSPI_DIV_W = 8;
    localparam int SSPI_BIT_W = 4;
    localparam logic [1:0] SSPI_CSTOP_HALF = 2'h3;
    localparam logic SSPI_SRC_CPU = 1'h1;
    localparam logic [2:0] SSPI_SYNC_RST = 3'h7;
    localparam int SSPI_SMP_DLY = 4;

    // =====================================================
    // state types
    typedef enum logic [2:0] {
        SSPI_IDLE,
        SSPI_LEAD,
        SSPI_LOW,
        SSPI_HIGH,
        SSPI_TAIL,
        SSPI_SLV
    } sspi_phase_t;

    typedef struct packed {
        logic [2:0] sclk;
        logic [2:0] tx_frame_sync_enable;
        logic [2:0] rx_frame_sync_enable;
        logic [2:0] din;
        logic [2:0] ext;
    } sspi_sync_t;

    typedef struct packed {
        sspi_phase_t phase;
        sspi_sync_t sy;
        logic sclk_st;
        logic sel_st;
        logic din_st;
        logic ext_st;
        logic half;
        logic tick;
        logic [SSPI_DIV_W-1:0] cnt;
        logic [SSPI_BIT_W-1:0] bits;
        logic [SSPI_WORD_W-1:0] txsh;
        logic [SSPI_WORD_W-1:0] rxsh;
        logic [SSPI_SMP_DLY-1:0] smp;
        logic fs_pin;
        logic [SSPI_WORD_W-1:0] rx_word;
        logic rx_valid;
        logic busy;
        logic sclk;
        logic sclk_oe;
        logic fs;
        logic fs_oe;
        logic dout;
        logic doe;
    } sspi_state_t;

endpackage

// file: dv/sspi_peer.sv
// spi peer model: slave or master facing the serial port
`timescale 1ns/1ps
`default_nettype none
module sspi_peer
    import sspi_pkg::*;
(
    // bench control
    input wire logic clk,
    input wire logic act_master,
    input wire logic go,
    input wire logic [SSPI_WORD_W-1:0] word_in,
    output logic [SSPI_WORD_W-1:0] word_out,
    output logic done,
    // serial pins
    input wire logic dut_sclk,
    input wire logic dut_sel_n,
    input wire logic dut_data,
    output logic sclk,
    output logic sel_n,
    output logic data
);
    localparam int PH = 8;
    logic [SSPI_WORD_W-1:0] sh = '0;
    logic [SSPI_WORD_W-1:0] wo = '0;
    logic ps = 1'h0;
    logic first = 1'h1;
    logic dn = 1'h0;
    logic ck = 1'h0;
    logic sn = 1'h1;
    logic dt = 1'h0;
    assign word_out = wo;
    assign done = dn;
    assign sclk = ck;
    assign sel_n = sn;
    assign data = dt;
    // ==========
    // master role when the design is slave, slave role otherwise
    always @(posedge clk) begin
        ps <= dut_sclk;
        if (act_master) begin
            if (go) begin
                sn <= 1'h0;
                dt <= word_in[SSPI_WORD_W-1];
                repeat (PH) @(posedge clk);
                for (int k = SSPI_WORD_W - 1; k >= 0; k--) begin
                    ck <= 1'h1;
                    wo <= {wo[SSPI_WORD_W-2:0], dut_data};
                    repeat (PH) @(posedge clk);
                    ck <= 1'h0;
                    dt <= word_in[(k + SSPI_WORD_W - 1) % SSPI_WORD_W];
                    repeat (PH) @(posedge clk);
                end
                sn <= 1'h1;
                dt <= ~dt;
                repeat (PH) @(posedge clk);
                dn <= 1'h1;
                @(posedge clk);
                dn <= 1'h0;
            end
        end else if (dut_sel_n) begin
            dt <= ~dt;
            sh <= word_in;
            first <= 1'h1;
        end else if (first || (ps && !dut_sclk)) begin
            dt <= sh[SSPI_WORD_W-1];
            sh <= sh << 1;
            first <= 1'h0;
        end else if (!ps && dut_sclk) begin
            wo <= {wo[SSPI_WORD_W-2:0], dut_data};
        end
    end
endmodule
`default_nettype wire

// file: dv/sspi_core_tb.sv
// self-checking testbench for the clock-stop spi serial port
`timescale 1ns/1ps
`default_nettype none
module sspi_core_tb;
    import sspi_pkg::*;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic src = 1'h1;
    logic mst = 1'h1;
    logic go = 1'h0;
    logic start = 1'h0;
    logic ext = 1'h0;
    logic flip = 1'h0;
    logic pol = 1'h1;
    logic [SSPI_DIV_W-1:0] div = 8'h01;
    logic [SSPI_WORD_W-1:0] txw = 8'h00;
    logic [SSPI_WORD_W-1:0] pw = 8'h00;
    logic [SSPI_WORD_W-1:0] pout, rxw;
    logic busy, rxv, sco, scoe, fso, fsoe, dto, dtoe, psclk, psel, pdat, pdone;
    wire logic sck = scoe ? sco : psclk;
    wire logic fs = fsoe ? fso : psel;
    wire logic dln = dtoe ? dto : flip;
    int num_errors = 0;
    int checks_done = 0;
    always #50 clk = ~clk;
    always #300 ext = ~ext;
    always @(posedge clk) flip <= ~flip;
    // ==========
    // design and peer
    sspi_core i_dut (.clk(clk), .sys_rst(sys_rst), .clock_stop_mode_select(2'h3), .tx_clock_polarity(1'h0),
        .generator_source_select(src), .generator_divide_value(div), .tx_clock_direction(mst),
        .rx_clock_direction(1'h0), .tx_sync_direction(mst), .rx_sync_direction(1'h0),
        .tx_sync_polarity(pol), .rx_sync_polarity(1'h1), .tx_start(start), .tx_word(txw), .busy(busy),
        .rx_word(rxw), .rx_valid(rxv), .generator_ext_clock_i(ext), .serial_bit_clock_i(sck),
        .serial_bit_clock_o(sco), .serial_bit_clock_oe(scoe), .tx_frame_sync_enable_i(fs),
        .tx_frame_sync_enable_o(fso), .tx_frame_sync_enable_oe(fsoe), .rx_frame_sync_enable_i(psel),
        .tx_serial_data_o(dto), .tx_serial_data_oe(dtoe), .rx_serial_data_i(pdat));
    sspi_peer i_peer (.clk(clk), .act_master(~mst), .go(go), .word_in(pw), .word_out(pout), .done(pdone),
        .dut_sclk(sck), .dut_sel_n(fs), .dut_data(dln), .sclk(psclk), .sel_n(psel), .data(pdat));
    // ==========
    // tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic mxfer(input logic [7:0] d, input logic s, input int sp, input logic [7:0] w, input logic [7:0] r);
        int h, l, n, tfs, toe, tr1, tf1, tr2, tlf, tof, tup, nv;
        logic ps;
        h = (d == 0) ? 1 : (d[0] ? (d + 1) / 2 : d / 2 + 1);
        l = (d == 0) ? 1 : (d[0] ? (d + 1) / 2 : d / 2);
        div = d;
        src = s;
        mst = 1'h1;
        txw = w;
        pw = r;
        {tfs, toe, tr1, tf1, tr2, tlf, tof, tup, nv, ps} = {{8{-32'sd1}}, 32'sd0, 1'b0};
        @(posedge clk);
        #1 start = 1'h1;
        @(posedge clk);
        #1 start = 1'h0;
        for (n = 0; n < 4000 && (n < 2 || tup < 0); n++) begin
            if (n == 0) check("busy", 32'(busy), 1);
            if (fs === 1'h0 && tfs < 0) tfs = n;
            if (dtoe === 1'h1 && toe < 0) toe = n;
            if (sck === 1'h1 && ps === 1'h0 && tr1 >= 0 && tr2 < 0) tr2 = n;
            if (sck === 1'h1 && ps === 1'h0 && tr1 < 0) tr1 = n;
            if (sck === 1'h0 && ps === 1'h1) tlf = n;
            if (sck === 1'h0 && ps === 1'h1 && tf1 < 0) tf1 = n;
            if (dtoe === 1'h0 && toe >= 0 && tof < 0) tof = n;
            if (fs === 1'h1 && tfs >= 0 && tup < 0) tup = n;
            if (rxv === 1'h1) nv++;
            ps = sck;
            @(posedge clk);
            #1;
        end
        if (n >= 4000) begin
            num_errors++;
            close_out();
        end
        check("oe_lead", 32'(toe - tfs > (h - 1) * sp && toe - tfs <= h * sp), 1);
        check("fs_lead", 32'(tr1 - tfs > (h + l - 1) * sp && tr1 - tfs <= (h + l) * sp), 1);
        check("low", tr1 - toe, l * sp);
        check("high", tf1 - tr1, h * sp);
        check("period", tr2 - tr1, (h + l) * sp);
        check("fs_hold", tup - tlf, l * sp);
        check("release", tof - tlf, 0);
        check("rx_word", 32'(rxw), 32'(r));
        check("peer_rx", 32'(pout), 32'(w));
        check("rx_pulse", nv, 1);
        check("mst_dirs", 32'({scoe, fsoe}), 3);
        check("idle_sck", 32'(sco), 0);
        $display("master transfer div %0d source %0d done", d, s);
    endtask
    task automatic sxfer(input logic [7:0] w, input logic [7:0] r);
        int n, tfs, toe;
        mst = 1'h0;
        src = 1'h1;
        div = 8'h01;
        txw = w;
        pw = r;
        tfs = -1;
        toe = -1;
        go = 1'h1;
        @(posedge clk);
        #1 go = 1'h0;
        for (n = 0; n < 4000 && pdone !== 1'h1; n++) begin
            if (psel === 1'h0 && tfs < 0) tfs = n;
            if (dtoe === 1'h1 && toe < 0) toe = n;
            @(posedge clk);
            #1;
        end
        if (n >= 4000) begin
            num_errors++;
            close_out();
        end
        @(posedge clk);
        #1;
        check("slv_first", 32'(toe >= tfs && toe - tfs <= 8), 1);
        check("slv_rx", 32'(rxw), 32'(r));
        check("peer_rx", 32'(pout), 32'(w));
        check("slv_release", 32'(dtoe), 0);
        check("slv_dirs", 32'({scoe, fsoe}), 0);
        $display("slave transfer %0h done", w);
    endtask
    // ==========
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        #1 sys_rst = 1'h0;
        check("idle_fs", 32'(fso), 1);
        check("idle_sck", 32'(sco), 0);
        mxfer(8'h01, 1'h1, 2, 8'ha5, 8'h3c);
        mxfer(8'h02, 1'h1, 2, 8'h81, 8'h7e);
        mxfer(8'h03, 1'h1, 2, 8'h5a, 8'hc3);
        mxfer(8'h00, 1'h1, 2, 8'hff, 8'h00);
        mxfer(8'h02, 1'h0, 6, 8'h69, 8'h96);
        pol = 1'h0;
        @(posedge clk);
        #1;
        check("fs_polarity", 32'(fso), 0);
        pol = 1'h1;
        sxfer(8'hb4, 8'h2d);
        sxfer(8'h01, 8'h80);
        close_out();
    end
endmodule
`default_nettype wire
